/* aes128_block_cipher_pkg.sv */
package aes128_block_cipher_pkg;

	// ==========================================================
	// Register map
	localparam logic [31:0] ADDR_CONTROL = 32'h40005e00;
	localparam logic [31:0] ADDR_INPUT = 32'h40005e08;
	localparam logic [31:0] ADDR_OUTPUT = 32'h40005e0c;
	localparam logic [31:0] ADDR_KEY_WORD_0 = 32'h40005e10;
	localparam logic [31:0] ADDR_KEY_WORD_1 = 32'h40005e14;
	localparam logic [31:0] ADDR_KEY_WORD_2 = 32'h40005e18;
	localparam logic [31:0] ADDR_KEY_WORD_3 = 32'h40005e1c;
	localparam logic [31:0] ADDR_IV_WORD_0 = 32'h40005e20;
	localparam logic [31:0] ADDR_IV_WORD_1 = 32'h40005e24;
	localparam logic [31:0] ADDR_IV_WORD_2 = 32'h40005e28;
	localparam logic [31:0] ADDR_IV_WORD_3 = 32'h40005e2c;
	localparam logic [31:0] ADDR_READBACK_WORD_0 = 32'h40005e30;
	localparam logic [31:0] ADDR_READBACK_WORD_1 = 32'h40005e34;
	localparam logic [31:0] ADDR_READBACK_WORD_2 = 32'h40005e38;
	localparam logic [31:0] ADDR_READBACK_WORD_3 = 32'h40005e3c;
	localparam logic [31:0] ADDR_EXP_KEY_WORD_0 = 32'h40005e40;
	localparam logic [31:0] ADDR_EXP_KEY_WORD_1 = 32'h40005e44;
	localparam logic [31:0] ADDR_EXP_KEY_WORD_2 = 32'h40005e48;
	localparam logic [31:0] ADDR_EXP_KEY_WORD_3 = 32'h40005e4c;

	// ==========================================================
	// Control register fields
	localparam int ENABLE_BIT = 0;
	localparam int OPSEL_LSB = 2;
	localparam int CHAIN_LSB = 6;
	localparam int DONE_FLAG_BIT = 8;
	localparam int OUT_EMPTY_BIT = 9;
	localparam logic [1:0] OP_ENCRYPT = 2'h0;
	localparam logic [1:0] OP_DECRYPT = 2'h1;
	localparam logic [1:0] OP_KEY_EXPAND = 2'h2;
	localparam logic [1:0] CHAIN_ECB = 2'h0;
	localparam logic [1:0] CHAIN_CBC = 2'h1;
	localparam logic [1:0] CHAIN_CTR = 2'h2;
	localparam logic [1:0] FIELD_RESET = 2'h0;
	localparam logic [3:0] FULL_WORD = 4'hf;

	// ==========================================================
	// Cipher and timing constants
	localparam logic [3:0] LAST_ROUND = 4'ha;
	localparam logic [3:0] FIRST_ROUND = 4'h1;
	localparam logic [2:0] WORDS_PER_BLOCK = 3'h4;
	localparam int COUNTER_WIDTH = 16;
	localparam int WORD_WIDTH = 32;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] RCON_FIRST = 8'h01;
	localparam logic [7:0] RCON_LAST = 8'h36;
	localparam logic [7:0] REDUCE_POLY = 8'h1b;
	localparam logic [7:0] INV_REDUCE_POLY = 8'h8d;
	localparam logic [7:0] SBOX_AFFINE = 8'h63;
	localparam logic [7:0] INV_AFFINE = 8'h05;

	typedef enum logic {CORE_IDLE, CORE_RUN} core_state_t;

endpackage

/* aes128_block_cipher_regs.sv */
// Summary of operation
// - Enable bit 0 gates cipher; rise reinitialises
// - Codebook chaining never reads the vector
// - Block starts after four input words
// - Key expansion done clears enable bit
// - Result read as four words, MSW first
// - Key expansion starts right at enable
// - Input word register: write-only, full word
// - Output word register: read-only, full word
// - Four key words, word 0 least significant
// - Four vector words, word 0 least significant
// - Four read-only input block read-back words
// - Four read-only expanded key words
// - Operation select: encrypt, decrypt, expand, reserved
// - Chaining select: codebook, chained, counter, reserved
// - Done flag set on completion, write-one clears
// - Counter mode increments low 16 vector bits
`timescale 1ns/1ps

// ==========================================================
// Input word buffer
module cipher_word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic flush,
	// Filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] input_block_bits,
	// Draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] output_block_bits
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr;
	logic [AW:0] rdPtr;

	assign inReady = (wrPtr - rdPtr) != FULL_COUNT;
	assign outValid = wrPtr != rdPtr;
	assign output_block_bits = mem[rdPtr[AW-1:0]];

	always_ff @(posedge mclk) begin
		if (inValid && inReady) begin
			mem[wrPtr[AW-1:0]] <= input_block_bits;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || flush) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (inValid && inReady) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (outValid && outReady) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end
endmodule

// ==========================================================
// Block cipher with register file
module aes128_block_cipher_regs (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	localparam int WW = aes128_block_cipher_pkg::WORD_WIDTH;
	localparam int CW = aes128_block_cipher_pkg::COUNTER_WIDTH;

	// ==========================================================
	// Field arithmetic
	function automatic logic [7:0] xt(input logic [7:0] b);
		return {b[6:0], 1'b0} ^
			(b[7] ? aes128_block_cipher_pkg::REDUCE_POLY : 8'h00);
	endfunction

	function automatic logic [7:0] gmul(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				p = p ^ x;
			end
			x = xt(x);
		end
		return p;
	endfunction

	// Inverse as x^254; zero maps to zero as the cipher needs.
	function automatic logic [7:0] ginv(input logic [7:0] x);
		logic [7:0] r;
		logic [7:0] y;
		r = 8'h01;
		y = x;
		for (int i = 1; i < 8; i++) begin
			y = gmul(y, y);
			r = gmul(r, y);
		end
		return r;
	endfunction

	function automatic logic [7:0] sbox(input logic [7:0] x);
		logic [7:0] b;
		b = ginv(x);
		return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]} ^
			{b[3:0], b[7:4]} ^ aes128_block_cipher_pkg::SBOX_AFFINE;
	endfunction

	function automatic logic [7:0] invSbox(input logic [7:0] s);
		logic [7:0] b;
		b = {s[6:0], s[7]} ^ {s[4:0], s[7:5]} ^ {s[1:0], s[7:2]} ^
			aes128_block_cipher_pkg::INV_AFFINE;
		return ginv(b);
	endfunction

	function automatic logic [31:0] subRot(input logic [31:0] w);
		return {sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0]),
			sbox(w[31:24])};
	endfunction

	function automatic logic [31:0] mixCol(input logic [31:0] c);
		logic [7:0] a0;
		logic [7:0] a1;
		logic [7:0] a2;
		logic [7:0] a3;
		{a0, a1, a2, a3} = c;
		return {xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3,
			a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3,
			a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3,
			xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3)};
	endfunction

	function automatic logic [31:0] invMixCol(input logic [31:0] c);
		logic [7:0] a0;
		logic [7:0] a1;
		logic [7:0] a2;
		logic [7:0] a3;
		{a0, a1, a2, a3} = c;
		return {gmul(a0, 8'h0e) ^ gmul(a1, 8'h0b) ^ gmul(a2, 8'h0d) ^
				gmul(a3, 8'h09),
			gmul(a0, 8'h09) ^ gmul(a1, 8'h0e) ^ gmul(a2, 8'h0b) ^
				gmul(a3, 8'h0d),
			gmul(a0, 8'h0d) ^ gmul(a1, 8'h09) ^ gmul(a2, 8'h0e) ^
				gmul(a3, 8'h0b),
			gmul(a0, 8'h0b) ^ gmul(a1, 8'h0d) ^ gmul(a2, 8'h09) ^
				gmul(a3, 8'h0e)};
	endfunction

	// ==========================================================
	// Registers and state
	logic enable;
	logic [1:0] opSel;
	logic [1:0] chainSel;
	logic doneFlag;
	logic outEmpty;
	logic [1:0] outIdx;
	logic [1:0] outSlot;
	logic [127:0] keyBits;
	logic [127:0] ivBits;
	logic [127:0] inBlock;
	logic [127:0] expKeyBits;
	logic [127:0] resultBits;
	logic [127:0] chainBits;
	logic [2:0] wordCount;
	logic keyPending;
	aes128_block_cipher_pkg::core_state_t coreState;
	logic [3:0] round;
	logic [127:0] st;
	logic [127:0] rk;
	logic [7:0] rcon;
	logic coreDec;
	logic coreKeyOnly;

	// ==========================================================
	// Bus decode
	logic access;
	logic xfer;
	logic isControl;
	logic isInput;
	logic isOutput;
	logic isKey;
	logic isIv;
	logic isReadback;
	logic isExpKey;
	logic mapped;
	logic readOnly;
	logic wordOnly;
	logic [31:0] readValue;
	logic [31:0] controlValue;
	logic ctrlWrite;
	logic enRise;
	logic [1:0] wordIdx;

	assign access = psel && penable;
	assign xfer = access && pready;
	assign wordIdx = paddr[3:2];
	// Inverted at two bits here; inside the product it would widen first.
	assign outSlot = ~outIdx;
	assign isControl = paddr == aes128_block_cipher_pkg::ADDR_CONTROL;
	assign isInput = paddr == aes128_block_cipher_pkg::ADDR_INPUT;
	assign isOutput = paddr == aes128_block_cipher_pkg::ADDR_OUTPUT;
	assign isKey = paddr[31:4] == aes128_block_cipher_pkg::ADDR_KEY_WORD_0[31:4]
		&& paddr[1:0] == 2'h0;
	assign isIv = paddr[31:4] == aes128_block_cipher_pkg::ADDR_IV_WORD_0[31:4]
		&& paddr[1:0] == 2'h0;
	assign isReadback = paddr[31:4] ==
		aes128_block_cipher_pkg::ADDR_READBACK_WORD_0[31:4] && paddr[1:0] == 2'h0;
	assign isExpKey = paddr[31:4] ==
		aes128_block_cipher_pkg::ADDR_EXP_KEY_WORD_0[31:4] && paddr[1:0] == 2'h0;
	assign mapped = isControl || isInput || isOutput || isKey || isIv ||
		isReadback || isExpKey;
	assign readOnly = isOutput || isReadback || isExpKey;
	assign wordOnly = !isControl && pstrb != aes128_block_cipher_pkg::FULL_WORD;
	assign ctrlWrite = xfer && pwrite && isControl;
	assign enRise = ctrlWrite && pstrb[0] &&
		pwdata[aes128_block_cipher_pkg::ENABLE_BIT] && !enable;
	assign controlValue = {22'h000000, outEmpty, doneFlag, chainSel, 2'h0,
		opSel, 1'b0, enable};

	always_comb begin
		readValue = 32'h00000000;
		if (isControl) begin
			readValue = controlValue;
		end else if (isOutput) begin
			readValue = resultBits[32*outSlot +: 32];
		end else if (isKey) begin
			readValue = keyBits[32*wordIdx +: 32];
		end else if (isIv) begin
			readValue = ivBits[32*wordIdx +: 32];
		end else if (isReadback) begin
			readValue = inBlock[32*wordIdx +: 32];
		end else if (isExpKey) begin
			readValue = expKeyBits[32*wordIdx +: 32];
		end
	end

	// ==========================================================
	// Input buffer
	logic fifoInValid;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoOutReady;
	logic [WW-1:0] fifoOutData;
	logic inputWrite;

	assign inputWrite = pwrite && isInput && pstrb ==
		aes128_block_cipher_pkg::FULL_WORD;
	assign fifoInValid = xfer && inputWrite && enable;
	assign fifoOutReady = enable && coreState ==
		aes128_block_cipher_pkg::CORE_IDLE && outEmpty &&
		wordCount != aes128_block_cipher_pkg::WORDS_PER_BLOCK &&
		(opSel == aes128_block_cipher_pkg::OP_ENCRYPT ||
		opSel == aes128_block_cipher_pkg::OP_DECRYPT);

	cipher_word_fifo #(
		.WIDTH(WW),
		.DEPTH(aes128_block_cipher_pkg::FIFO_DEPTH)
	) inputFifo (
		.mclk(mclk),
		.rst(rst),
		.flush(enRise),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.input_block_bits(pwdata),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.output_block_bits(fifoOutData)
	);

	// ==========================================================
	// APB answer: one wait state, longer while the buffer is full.
	always_ff @(posedge mclk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (pready) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (access && !(inputWrite && enable && !fifoInReady)) begin
			pready <= 1'b1;
			pslverr <= !mapped || (pwrite && (readOnly || wordOnly));
			prdata <= pwrite ? 32'h00000000 : readValue;
		end
	end

	// ==========================================================
	// Control register
	logic coreFinish;

	always_ff @(posedge mclk) begin
		if (rst) begin
			enable <= 1'b0;
			opSel <= aes128_block_cipher_pkg::FIELD_RESET;
			chainSel <= aes128_block_cipher_pkg::FIELD_RESET;
		end else begin
			if (ctrlWrite && pstrb[0]) begin
				enable <= pwdata[aes128_block_cipher_pkg::ENABLE_BIT];
				// Modes are frozen while enabled to keep a block consistent.
				if (!enable) begin
					opSel <= pwdata[aes128_block_cipher_pkg::OPSEL_LSB +: 2];
					chainSel <= pwdata[aes128_block_cipher_pkg::CHAIN_LSB +: 2];
				end
			end
			if (coreFinish && coreKeyOnly) begin
				enable <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			doneFlag <= 1'b0;
		end else if (coreFinish) begin
			doneFlag <= 1'b1;
		end else if (ctrlWrite && pstrb[1] &&
			pwdata[aes128_block_cipher_pkg::DONE_FLAG_BIT]) begin
			doneFlag <= 1'b0;
		end
	end

	// ==========================================================
	// Key, vector and block registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			keyBits <= '0;
			ivBits <= '0;
		end else if (xfer && pwrite && pstrb ==
			aes128_block_cipher_pkg::FULL_WORD) begin
			if (isKey) begin
				keyBits[32*wordIdx +: 32] <= pwdata;
			end
			if (isIv) begin
				ivBits[32*wordIdx +: 32] <= pwdata;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || enRise) begin
			wordCount <= 3'h0;
			inBlock <= '0;
		end else if (fifoOutValid && fifoOutReady) begin
			inBlock <= {inBlock[95:0], fifoOutData};
			wordCount <= wordCount + 3'h1;
		end else if (coreState == aes128_block_cipher_pkg::CORE_IDLE &&
			wordCount == aes128_block_cipher_pkg::WORDS_PER_BLOCK && enable &&
			outEmpty) begin
			wordCount <= 3'h0;
		end
	end

	// ==========================================================
	// Round datapath
	wire [127:0] subV;
	wire [127:0] invSubV;
	wire [127:0] mixV;
	wire [127:0] invMixV;
	logic [127:0] rkEnc;
	logic [127:0] rkDec;
	logic [127:0] decAdd;
	logic [127:0] roundOut;
	logic [31:0] dw3;
	logic [31:0] dw2;
	logic [31:0] dw1;

	for (genvar i = 0; i < 16; i++) begin : gByte
		localparam int C = i / 4;
		localparam int R = i % 4;
		assign subV[127-8*i -: 8] = sbox(st[127-8*(4*((C+R)%4)+R) -: 8]);
		assign invSubV[127-8*i -: 8] =
			invSbox(st[127-8*(4*((C+4-R)%4)+R) -: 8]);
	end
	for (genvar j = 0; j < 4; j++) begin : gCol
		assign mixV[127-32*j -: 32] = mixCol(subV[127-32*j -: 32]);
		assign invMixV[127-32*j -: 32] = invMixCol(decAdd[127-32*j -: 32]);
	end

	always_comb begin
		rkEnc[127:96] = rk[127:96] ^ subRot(rk[31:0]) ^ {rcon, 24'h000000};
		rkEnc[95:64] = rk[95:64] ^ rkEnc[127:96];
		rkEnc[63:32] = rk[63:32] ^ rkEnc[95:64];
		rkEnc[31:0] = rk[31:0] ^ rkEnc[63:32];
		dw3 = rk[31:0] ^ rk[63:32];
		dw2 = rk[63:32] ^ rk[95:64];
		dw1 = rk[95:64] ^ rk[127:96];
		rkDec = {rk[127:96] ^ subRot(dw3) ^ {rcon, 24'h000000}, dw1, dw2, dw3};
		decAdd = invSubV ^ rkDec;
		if (coreDec) begin
			roundOut = round == aes128_block_cipher_pkg::LAST_ROUND ?
				decAdd : invMixV;
		end else begin
			roundOut = (round == aes128_block_cipher_pkg::LAST_ROUND ?
				subV : mixV) ^ rkEnc;
		end
	end

	// ==========================================================
	// Core sequencer
	logic startBlock;
	logic startKey;
	logic useCounter;
	logic [127:0] coreIn;

	assign useCounter = chainSel == aes128_block_cipher_pkg::CHAIN_CTR;
	assign startBlock = enable && coreState ==
		aes128_block_cipher_pkg::CORE_IDLE && outEmpty &&
		wordCount == aes128_block_cipher_pkg::WORDS_PER_BLOCK;
	assign startKey = enable && coreState ==
		aes128_block_cipher_pkg::CORE_IDLE && keyPending;
	assign coreFinish = coreState == aes128_block_cipher_pkg::CORE_RUN &&
		round == aes128_block_cipher_pkg::LAST_ROUND && enable;

	always_comb begin
		coreIn = inBlock;
		if (useCounter) begin
			coreIn = chainBits;
		end else if (chainSel == aes128_block_cipher_pkg::CHAIN_CBC &&
			opSel == aes128_block_cipher_pkg::OP_ENCRYPT) begin
			coreIn = inBlock ^ chainBits;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || enRise) begin
			keyPending <= enRise && pwdata[aes128_block_cipher_pkg::OPSEL_LSB +: 2]
				== aes128_block_cipher_pkg::OP_KEY_EXPAND;
		end else if (startKey) begin
			keyPending <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || enRise) begin
			coreState <= aes128_block_cipher_pkg::CORE_IDLE;
			round <= aes128_block_cipher_pkg::FIRST_ROUND;
			st <= '0;
			rk <= '0;
			rcon <= aes128_block_cipher_pkg::RCON_FIRST;
			coreDec <= 1'b0;
			coreKeyOnly <= 1'b0;
		end else begin
			case (coreState)
				aes128_block_cipher_pkg::CORE_IDLE: begin
					if (startBlock || startKey) begin
						// The key is taken here, so it must be loaded first.
						coreState <= aes128_block_cipher_pkg::CORE_RUN;
						round <= aes128_block_cipher_pkg::FIRST_ROUND;
						st <= coreIn ^ keyBits;
						rk <= keyBits;
						coreKeyOnly <= startKey;
						// Counter mode reuses the forward cipher both ways.
						coreDec <= startBlock && !useCounter &&
							opSel == aes128_block_cipher_pkg::OP_DECRYPT;
						rcon <= (startBlock && !useCounter && opSel ==
							aes128_block_cipher_pkg::OP_DECRYPT) ?
							aes128_block_cipher_pkg::RCON_LAST :
							aes128_block_cipher_pkg::RCON_FIRST;
					end
				end
				aes128_block_cipher_pkg::CORE_RUN: begin
					if (!enable) begin
						coreState <= aes128_block_cipher_pkg::CORE_IDLE;
					end else begin
						st <= roundOut;
						rk <= coreDec ? rkDec : rkEnc;
						rcon <= coreDec ? ({1'b0, rcon[7:1]} ^ (rcon[0] ?
							aes128_block_cipher_pkg::INV_REDUCE_POLY : 8'h00)) :
							xt(rcon);
						round <= round + 4'h1;
						if (round == aes128_block_cipher_pkg::LAST_ROUND) begin
							coreState <= aes128_block_cipher_pkg::CORE_IDLE;
						end
					end
				end
				default: coreState <= aes128_block_cipher_pkg::CORE_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Results and chaining state
	logic outPop;

	assign outPop = xfer && !pwrite && isOutput && !outEmpty;

	always_ff @(posedge mclk) begin
		if (rst) begin
			expKeyBits <= '0;
		end else if (coreFinish && coreKeyOnly) begin
			expKeyBits <= rkEnc;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			chainBits <= '0;
		end else if (enRise) begin
			chainBits <= ivBits;
		end else if (coreFinish && !coreKeyOnly) begin
			if (useCounter) begin
				chainBits[CW-1:0] <= chainBits[CW-1:0] + 16'h0001;
			end else if (opSel == aes128_block_cipher_pkg::OP_ENCRYPT) begin
				chainBits <= roundOut;
			end else begin
				chainBits <= inBlock;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			resultBits <= '0;
		end else if (coreFinish && !coreKeyOnly) begin
			if (useCounter) begin
				resultBits <= roundOut ^ inBlock;
			end else if (chainSel == aes128_block_cipher_pkg::CHAIN_CBC &&
				opSel == aes128_block_cipher_pkg::OP_DECRYPT) begin
				resultBits <= roundOut ^ chainBits;
			end else begin
				resultBits <= roundOut;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || enRise) begin
			outEmpty <= 1'b1;
			outIdx <= 2'h0;
		end else if (coreFinish && !coreKeyOnly) begin
			outEmpty <= 1'b0;
			outIdx <= 2'h0;
		end else if (outPop) begin
			outIdx <= outIdx + 2'h1;
			if (outIdx == 2'h3) begin
				outEmpty <= 1'b1;
			end
		end
	end
endmodule

/* aes128_block_cipher_regs_props.sv */
`timescale 1ns/1ps
// ==========================================================
// Bus answer checks
module aes128_block_cipher_regs_props (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic acc;
	assign acc = psel && penable && !pready;
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside an access");
	a_read_answer: assert property (acc && !pwrite |=> pready)
		else $error("read not answered next cycle");
	a_input_read_zero: assert property (acc && !pwrite &&
		paddr == aes128_block_cipher_pkg::ADDR_INPUT |=> prdata == 32'h0)
		else $error("input word read not zero");
	a_gap_error: assert property (acc && paddr == 32'h40005e04 |=> pslverr)
		else $error("gap address not refused");
	a_output_write_err: assert property (acc && pwrite &&
		paddr == aes128_block_cipher_pkg::ADDR_OUTPUT |=> pslverr)
		else $error("output word write not refused");
	a_key_partial_err: assert property (acc && pwrite && pstrb != 4'hf &&
		paddr == aes128_block_cipher_pkg::ADDR_KEY_WORD_0 |=> pslverr)
		else $error("partial key write not refused");
	a_key_write_ok: assert property (acc && pwrite && pstrb == 4'hf &&
		paddr == aes128_block_cipher_pkg::ADDR_KEY_WORD_3 |=> pready && !pslverr)
		else $error("full key write refused");
	a_readonly_err: assert property (acc && pwrite &&
		paddr >= aes128_block_cipher_pkg::ADDR_READBACK_WORD_0 &&
		paddr <= aes128_block_cipher_pkg::ADDR_EXP_KEY_WORD_3 |=> pslverr)
		else $error("read-only word write not refused");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst |=> !pready && !pslverr)
		else $error("answer during reset");
endmodule

/* aes128_block_cipher_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("[ERR] %s @%h exp %h got %h", n, paddr, e, g); \
	end \
end
// ==========================================================
// Register-level bench
module aes128_block_cipher_regs_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] rd;
	logic er;
	int fail_count = 0;
	int total_checks = 0;
	localparam logic [31:0] CTL = aes128_block_cipher_pkg::ADDR_CONTROL;
	localparam logic [31:0] INW = aes128_block_cipher_pkg::ADDR_INPUT;
	localparam logic [31:0] OUTW = aes128_block_cipher_pkg::ADDR_OUTPUT;
	localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
	localparam logic [127:0] PT = 128'h00112233445566778899aabbccddeeff;
	localparam logic [127:0] CT = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
	localparam logic [127:0] RK = 128'h13111d7fe3944a17f307a78b4d2b30c5;
	// Counter one below the plain block, so the second block uses it.
	localparam logic [127:0] IVC = 128'h00112233445566778899aabbccddeefe;
	always #50 mclk = ~mclk;
	aes128_block_cipher_regs uut (
		.mclk(mclk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);
	task automatic end_sim();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Request is held until the edge that samples pready high.
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic e);
		xfer(1'b1, a, d, s);
		`CHK("write error", e, er)
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, 4'h0);
		`CHK("read data", e, rd)
	endtask
	task automatic wait_done();
		for (int i = 0; i < 60; i++) begin
			xfer(1'b0, CTL, 32'h0, 4'h0);
			if (rd[8] === 1'b1) break;
		end
		`CHK("done flag", 1'b1, rd[8])
	endtask
	task automatic blk(input logic [127:0] d);
		for (int i = 3; i >= 0; i--) wr(INW, d[32*i+:32], 4'hf, 1'b0);
		wait_done();
	endtask
	task automatic rdo(input logic [127:0] e);
		for (int i = 3; i >= 0; i--) rdc(OUTW, e[32*i+:32]);
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rdc(CTL, 32'h200);
		for (int i = 0; i < 4; i++) begin
			wr(CTL + 32'h10 + 4 * i, KEY[32*i+:32], 4'hf, 1'b0);
			wr(CTL + 32'h20 + 4 * i, ~KEY[32*i+:32], 4'hf, 1'b0);
		end
		for (int i = 0; i < 4; i++) begin
			rdc(CTL + 32'h10 + 4 * i, KEY[32*i+:32]);
			rdc(CTL + 32'h20 + 4 * i, ~KEY[32*i+:32]);
		end
		wr(32'h40005e04, 32'h1, 4'hf, 1'b1);
		wr(OUTW, 32'h1, 4'hf, 1'b1);
		wr(CTL + 32'h10, 32'h5a, 4'h3, 1'b1);
		rdc(CTL + 32'h10, KEY[31:0]);
		wr(CTL + 32'h30, 32'h1, 4'hf, 1'b1);
		wr(CTL + 32'h44, 32'h1, 4'hf, 1'b1);
		rdc(INW, 32'h0);
		wr(INW, 32'h77, 4'hf, 1'b0);
		wr(CTL, 32'h1, 4'hf, 1'b0);
		for (int i = 3; i > 0; i--) wr(INW, PT[32*i+:32], 4'hf, 1'b0);
		repeat (40) @(posedge mclk);
		rdc(CTL, 32'h201);
		wr(INW, PT[31:0], 4'hf, 1'b0);
		wait_done();
		rdc(CTL, 32'h101);
		for (int i = 0; i < 4; i++) rdc(CTL + 32'h30 + 4 * i, PT[32*i+:32]);
		for (int i = 3; i >= 0; i--) rdc(OUTW, CT[32*i+:32]);
		rdc(CTL, 32'h301);
		wr(CTL, 32'h101, 4'hf, 1'b0);
		rdc(CTL, 32'h201);
		wr(CTL, 32'h0, 4'hf, 1'b0);
		wr(CTL, 32'h8, 4'hf, 1'b0);
		wr(CTL, 32'h9, 4'hf, 1'b0);
		wait_done();
		rdc(CTL, 32'h308);
		for (int i = 0; i < 4; i++) rdc(CTL + 32'h40 + 4 * i, RK[32*i+:32]);
		wr(CTL, 32'h104, 4'hf, 1'b0);
		for (int i = 0; i < 4; i++) wr(CTL + 32'h10 + 4 * i, RK[32*i+:32], 4'hf, 1'b0);
		wr(CTL, 32'h105, 4'hf, 1'b0);
		for (int i = 3; i >= 0; i--) wr(INW, CT[32*i+:32], 4'hf, 1'b0);
		wait_done();
		for (int i = 3; i >= 0; i--) rdc(OUTW, PT[32*i+:32]);
		wr(CTL, 32'h144, 4'hf, 1'b0);
		wr(CTL, 32'h145, 4'hf, 1'b0);
		blk(CT);
		rdo(PT ^ ~KEY);
		wr(CTL, 32'h145, 4'hf, 1'b0);
		blk(CT);
		rdo(PT ^ CT);
		wr(CTL, 32'h180, 4'hf, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wr(CTL + 32'h10 + 4 * i, KEY[32*i+:32], 4'hf, 1'b0);
			wr(CTL + 32'h20 + 4 * i, IVC[32*i+:32], 4'hf, 1'b0);
		end
		wr(CTL, 32'h181, 4'hf, 1'b0);
		blk(128'h0);
		repeat (4) xfer(1'b0, OUTW, 32'h0, 4'h0);
		wr(CTL, 32'h181, 4'hf, 1'b0);
		blk(PT);
		rdo(CT ^ PT);
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		end_sim();
	end
endmodule
bind aes128_block_cipher_regs aes128_block_cipher_regs_props chk (
	.mclk(mclk),
	.rst(rst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pstrb(pstrb),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr)
);
